// ===== uart_consts.svh
// Purpose: Constants of the serial port divisor, data and status block.
// Assumes: APB byte address is four times the register index.
// Notes:   Field positions are bit numbers inside each 8-bit register.
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH

// Register indices
`define IDX_DATA      12'hf40
`define IDX_LSTAT     12'hf41
`define IDX_CTRL0     12'hf42
`define IDX_CTRL1     12'hf43
`define IDX_MSTAT     12'hf44
`define IDX_DIV_HI    12'hf46
`define IDX_DIV_LO    12'hf47

// Control 0 fields
`define C0_TEN        7
`define C0_REN        6
`define C0_CTSE       5
`define C0_PEN        4
`define C0_PSEL       3
`define C0_SBRK       2
`define C0_STOP       1
`define C0_LBEN       0

// Control 1 fields
`define C1_MPEN       6
`define C1_MPBT       4
`define C1_DIVISOR_TIMER_IRQ_ENABLE       2

// Multinode status fields
`define MS_FIRST_DATA_OF_FRAME     1
`define MS_NINTH      0

// Reset values
`define CTRL_RST      8'h00
`define DIV_RST       16'hffff

// Oversampling and frame bit-count figures
`define OS_LAST       4'hf
`define OS_MID        4'h7
`define TX_BASE_BITS  4'ha
`define RX_BASE_LAST  4'h8

`endif

// ===== uart_pkg.sv
// Purpose: Types of the serial port divisor, data and status block.
// Assumes: Constants live in uart_consts.svh.
// Notes:   All module state except the assertion helper counters is one packed struct.
package uart_pkg;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} rx_state_e;

    typedef enum logic [2:0] {
        SEL_DATA, SEL_LSTAT, SEL_CTRL0, SEL_CTRL1,
        SEL_MSTAT, SEL_DIV_HI, SEL_DIV_LO, SEL_NONE
    } reg_sel_e;

    typedef struct packed {
        logic [7:0]  ctrl0;
        logic [7:0]  ctrl1;
        logic [15:0] div;
        logic [15:0] cnt;
        logic [7:0]  tx_hold;
        logic        hold_full;
        logic        tx_active;
        logic [11:0] tx_sh;
        logic [3:0]  tx_bits;
        logic [3:0]  tx_os;
        logic        tx_out;
        rx_state_e   rx_st;
        logic [3:0]  rx_os;
        logic [3:0]  rx_bit;
        logic [9:0]  rx_sh;
        logic [7:0]  rx_data;
        logic        rx_byte_waiting;
        logic        pe;
        logic        oe;
        logic        fe;
        logic        break_seen_flag;
        logic        first_data_of_frame;
        logic        last_ninth_bit;
        logic        addr_seen;
        logic        irq;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } uart_state_s;

endpackage : uart_pkg

// ===== uart_baud_and_data_status.sv
// Purpose: Divisor counter, data registers and status of a serial port.
// Assumes: Single clock pclk; pins synchronous to it; APB slave with 14-bit address.
// Notes:   Divisor counter doubles as a timer when transmitter and receiver are off.
//
// Overview of operation
// R1: Divisor is high byte then low byte.
// R2: Bit rate is clock over sixteen times divisor.
// R3: Counter keeps timing while port is disabled.
// R4: Software disables port, loads count, enables interrupt.
// R5: Timer interval equals divisor clock periods.
// R6: Data write loads byte to transmit.
// R7: Data read returns last received byte.
// R8: Byte waiting flag set on load, read clears.
// R9: Parity flag set on mismatch, read clears.
// R10: Overrun flag; read clears only when none waiting.
// R11: Framing flag set on missing stop bit.
// R12: Break flag when whole character is zero.
// R13: Holding empty resets one, write clears it.
// R14: Shift idle reads zero while sending.
// R15: Bit zero returns clear-to-send pin level.
// R16: Reserved multinode bits read and write zero.
// R17: First data of frame bit, read clears.
// R18: Ninth bit of last character, read clears.
// R19: Divisor reload raises receiver interrupt when enabled.
// R20: Overrun keeps the byte already held.
// R21: Counter counts down, reloads, one tick per reload.
`timescale 1ns/100ps
`include "uart_consts.svh"

module uart_baud_and_data_status
    import uart_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [13:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial line
    input  wire logic        serial_in_pin,
    input  wire logic        cts_n,
    output logic             serial_out_pin,
    // Receiver interrupt, high one cycle per new byte or divisor reload
    output logic             rx_irq
);

    // Address decode, shared by read mux and write path
    function automatic reg_sel_e reg_sel(input logic [13:0] a);
        reg_sel_e r;
        r = SEL_NONE;
        if (a == {`IDX_DATA, 2'b00})   r = SEL_DATA;
        if (a == {`IDX_LSTAT, 2'b00})  r = SEL_LSTAT;
        if (a == {`IDX_CTRL0, 2'b00})  r = SEL_CTRL0;
        if (a == {`IDX_CTRL1, 2'b00})  r = SEL_CTRL1;
        if (a == {`IDX_MSTAT, 2'b00})  r = SEL_MSTAT;
        if (a == {`IDX_DIV_HI, 2'b00}) r = SEL_DIV_HI;
        if (a == {`IDX_DIV_LO, 2'b00}) r = SEL_DIV_LO;
        return r;
    endfunction : reg_sel

    // Ninth bit: multinode flag when enabled, else parity of the byte
    function automatic logic ninth_of(input logic [7:0] d, input logic mp,
                                      input logic mpbt, input logic odd);
        return mp ? mpbt : (^d ^ odd);
    endfunction : ninth_of

    uart_state_s s;
    uart_state_s n;

    logic        tick;
    logic        setup;
    logic        acc;
    logic        data_rd;
    logic        data_wr;
    logic        rx_done;
    logic        rda_left;
    logic        extra;
    logic        rxi;
    logic        brk;
    logic        ninth;
    logic        tx_shift_idle;
    logic [9:0]  w;
    logic [7:0]  rd_byte;
    reg_sel_e    sel;

    // Next state of the whole block
    always_comb begin
        n        = s;
        sel      = reg_sel(paddr);
        setup    = psel & ~penable;
        acc      = psel & penable & s.pready;
        data_rd  = acc & ~pwrite & (sel == SEL_DATA);
        data_wr  = acc & pwrite & (sel == SEL_DATA);
        extra    = s.ctrl0[`C0_PEN] | s.ctrl1[`C1_MPEN];
        tx_shift_idle      = ~s.tx_active & ~s.hold_full;
        rx_done  = 1'b0;
        w        = s.rx_sh;
        brk      = 1'b0;
        ninth    = 1'b0;
        rd_byte  = 8'h00;

        // Down counter, reload at end gives period of div clocks
        tick  = (s.cnt <= 16'h0001);                                   // R21
        n.cnt = tick ? s.div : s.cnt - 16'h0001;                        // R2 R5 R21

        // Transmit shifter: one bit per sixteen ticks
        if (s.tx_active) begin
            if (tick) begin
                n.tx_os = s.tx_os + 4'h1;
                if (s.tx_os == `OS_LAST) begin                          // R2
                    n.tx_sh   = {1'b1, s.tx_sh[11:1]};
                    n.tx_bits = s.tx_bits - 4'h1;
                    if (s.tx_bits == 4'h1) begin
                        n.tx_active = 1'b0;                             // R14
                    end
                end
            end
        end else if (s.hold_full && s.ctrl0[`C0_TEN] &&
                     (~s.ctrl0[`C0_CTSE] | ~cts_n)) begin
            // Frame: start, data, optional ninth, stop bits
            n.tx_sh = extra ?
                {2'b11, ninth_of(s.tx_hold, s.ctrl1[`C1_MPEN], s.ctrl1[`C1_MPBT],
                                 s.ctrl0[`C0_PSEL]), s.tx_hold, 1'b0} :
                {3'b111, s.tx_hold, 1'b0};                              // R6
            n.tx_bits   = `TX_BASE_BITS + {3'b000, extra} + {3'b000, s.ctrl0[`C0_STOP]};
            n.tx_os     = 4'h0;
            n.tx_active = 1'b1;
            n.hold_full = 1'b0;                                         // R13
        end
        // Send break holds the line low
        n.tx_out = s.ctrl0[`C0_SBRK] ? 1'b0 : (n.tx_active ? n.tx_sh[0] : 1'b1);

        // Receiver, optionally looped back from the transmitter
        rxi = s.ctrl0[`C0_LBEN] ? s.tx_out : serial_in_pin;
        unique case (s.rx_st)
            RX_IDLE: begin
                if (s.ctrl0[`C0_REN] && tick && !rxi) begin
                    n.rx_st = RX_START;
                    n.rx_os = 4'h0;
                end
            end
            RX_START: begin
                if (tick) begin
                    n.rx_os = s.rx_os + 4'h1;
                    if (s.rx_os == `OS_MID) begin
                        // Glitch filter: start must still be low mid-bit
                        n.rx_st  = rxi ? RX_IDLE : RX_BITS;
                        n.rx_os  = 4'h0;
                        n.rx_bit = 4'h0;
                    end
                end
            end
            RX_BITS: begin
                if (tick) begin
                    n.rx_os = s.rx_os + 4'h1;
                    if (s.rx_os == `OS_LAST) begin
                        w[s.rx_bit] = rxi;
                        n.rx_sh     = w;
                        n.rx_bit    = s.rx_bit + 4'h1;
                        if (s.rx_bit == `RX_BASE_LAST + {3'b000, extra}) begin
                            rx_done = 1'b1;
                            n.rx_st = RX_IDLE;
                        end
                    end
                end
            end
        endcase
        if (!s.ctrl0[`C0_REN]) begin
            n.rx_st = RX_IDLE;
        end

        ninth = extra & w[8];
        brk   = (w[7:0] == 8'h00) & ~ninth & ~rxi;                      // R12

        // Read of receive data clears the receive flags, overrun only when no byte was waiting
        if (data_rd) begin
            n.rx_byte_waiting    = 1'b0;                                            // R8
            n.pe     = 1'b0;                                            // R9
            n.fe     = 1'b0;                                            // R11
            n.break_seen_flag   = 1'b0;                                            // R12
            n.first_data_of_frame = 1'b0;                                            // R17
            n.last_ninth_bit   = 1'b0;                                            // R18
            if (!s.rx_byte_waiting) begin
                n.oe = 1'b0;                                            // R10
            end
        end
        // Completion after clears, so a set in the same cycle wins
        rda_left = s.rx_byte_waiting & ~data_rd;
        if (rx_done) begin
            if (rda_left) begin
                n.oe = 1'b1;                                            // R10 R20
                if (brk) begin
                    n.break_seen_flag = 1'b1;
                end
            end else begin
                n.rx_data = w[7:0];                                     // R7
                n.rx_byte_waiting     = 1'b1;                                       // R8
                n.pe      = s.ctrl0[`C0_PEN] & ~s.ctrl1[`C1_MPEN] &
                            ((^w[7:0] ^ w[8]) != s.ctrl0[`C0_PSEL]);    // R9
                n.fe      = ~rxi;                                       // R11
                n.break_seen_flag    = brk;                                        // R12
                n.last_ninth_bit    = ninth;                                      // R18
                if (s.ctrl1[`C1_MPEN]) begin
                    if (ninth) begin
                        n.addr_seen = 1'b1;
                    end else if (s.addr_seen) begin
                        n.first_data_of_frame    = 1'b1;                             // R17
                        n.addr_seen = 1'b0;
                    end
                end
            end
        end

        // Receiver interrupt: new byte, or divisor reload in timer use
        n.irq = (tick & s.ctrl1[`C1_DIVISOR_TIMER_IRQ_ENABLE]) | (rx_done & ~rda_left);    // R3 R19

        // Read mux, data captured in the setup cycle
        unique case (sel)
            // A byte landing in the setup cycle is returned, else the read would drop it
            SEL_DATA:   rd_byte = (rx_done & ~rda_left) ? w[7:0] : s.rx_data; // R7
            SEL_LSTAT:  rd_byte = {s.rx_byte_waiting, s.pe, s.oe, s.fe, s.break_seen_flag,
                                   ~s.hold_full, tx_shift_idle, cts_n};           // R13 R14 R15
            SEL_CTRL0:  rd_byte = s.ctrl0;
            SEL_CTRL1:  rd_byte = s.ctrl1;
            SEL_MSTAT:  rd_byte = {6'h00, s.first_data_of_frame, s.last_ninth_bit};            // R16
            SEL_DIV_HI: rd_byte = s.ctrl1[`C1_DIVISOR_TIMER_IRQ_ENABLE] ? s.cnt[15:8] : s.div[15:8];
            SEL_DIV_LO: rd_byte = s.ctrl1[`C1_DIVISOR_TIMER_IRQ_ENABLE] ? s.cnt[7:0] : s.div[7:0];
            SEL_NONE:   rd_byte = 8'h00;
        endcase
        // Zero-wait slave: pready high in every access phase
        n.pready  = setup;
        n.pslverr = setup & (sel == SEL_NONE);
        if (setup) begin
            n.prdata = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        end

        // Register writes at the completing access edge
        if (acc && pwrite) begin
            unique case (sel)
                SEL_DATA: begin
                    n.tx_hold   = pwdata[7:0];                          // R6
                    n.hold_full = 1'b1;                                 // R13
                end
                SEL_CTRL0:  n.ctrl0       = pwdata[7:0];
                SEL_CTRL1:  n.ctrl1       = pwdata[7:0];
                SEL_DIV_HI: n.div[15:8]   = pwdata[7:0];                // R1
                SEL_DIV_LO: n.div[7:0]    = pwdata[7:0];                // R1
                SEL_LSTAT, SEL_MSTAT, SEL_NONE: begin
                    // Status has nothing writable; ignored
                end
            endcase
        end
    end

    // Single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s           <= '0;
            s.ctrl0     <= `CTRL_RST;
            s.ctrl1     <= `CTRL_RST;
            s.div       <= `DIV_RST;
            s.cnt       <= `DIV_RST;
            s.tx_sh     <= 12'hfff;
            s.tx_out    <= 1'b1;
            s.rx_st     <= RX_IDLE;
        end else begin
            s <= n;
        end
    end

    // Outputs straight from the state flops
    assign prdata         = s.prdata;
    assign pready         = s.pready;
    assign pslverr        = s.pslverr;
    assign serial_out_pin = s.tx_out;
    assign rx_irq         = s.irq;

    // Helper: clocks since the last tick, valid only with divisor untouched
    logic [16:0] gap_cnt;
    logic        gap_ok;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_cnt <= 17'h00001;
            gap_ok  <= 1'b0;
        end else begin
            gap_cnt <= tick ? 17'h00001 : gap_cnt + 17'h00001;
            if (acc && pwrite && (sel == SEL_DIV_HI || sel == SEL_DIV_LO)) begin
                gap_ok <= 1'b0;
            end else if (tick) begin
                gap_ok <= 1'b1;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_data_rd_setup;
        psel && !penable && !pwrite && reg_sel(paddr) == SEL_DATA;
    endsequence

    property p_reload_from_div;
        tick |=> s.cnt == $past(s.div);
    endproperty
    a_reload_from_div: assert property (p_reload_from_div) // R21
        else $error("counter did not reload from divisor");

    property p_tick_period;
        tick && gap_ok && s.div != 16'h0000 |-> gap_cnt == {1'b0, s.div};
    endproperty
    a_tick_period: assert property (p_tick_period) // R5
        else $error("tick interval differs from divisor");

    property p_irq_on_reload;
        tick && s.ctrl1[`C1_DIVISOR_TIMER_IRQ_ENABLE] |=> rx_irq;
    endproperty
    a_irq_on_reload: assert property (p_irq_on_reload) // R19
        else $error("no interrupt on divisor reload");

    property p_rd_clears_rda;
        s_data_rd_setup ##1 (acc && !rx_done) |=> !s.rx_byte_waiting && !s.pe && !s.fe;
    endproperty
    a_rd_clears_rda: assert property (p_rd_clears_rda) // R8
        else $error("data read left receive flags set");

    property p_wr_clears_empty;
        data_wr |=> s.hold_full && s.tx_hold == $past(pwdata[7:0]);
    endproperty
    a_wr_clears_empty: assert property (p_wr_clears_empty) // R13
        else $error("holding empty not cleared by write");

    property p_busy_not_idle;
        psel && !penable && !pwrite && reg_sel(paddr) == SEL_LSTAT && s.tx_active |=>
            !prdata[1];
    endproperty
    a_busy_not_idle: assert property (p_busy_not_idle) // R14
        else $error("shift idle set while sending");

    property p_overrun_keeps;
        rx_done && rda_left |=> s.oe && s.rx_data == $past(s.rx_data);
    endproperty
    a_overrun_keeps: assert property (p_overrun_keeps) // R20
        else $error("overrun overwrote held byte");

    property p_start_bit;
        !s.tx_active ##1 s.tx_active && !s.ctrl0[`C0_SBRK] |-> !serial_out_pin;
    endproperty
    a_start_bit: assert property (p_start_bit) // R6
        else $error("frame did not open with a low start bit");

    property p_mstat_reserved;
        psel && !penable && !pwrite && reg_sel(paddr) == SEL_MSTAT |=>
            prdata[31:2] == 30'h0000_0000;
    endproperty
    a_mstat_reserved: assert property (p_mstat_reserved) // R16
        else $error("reserved multinode bits not zero");

    property p_cts_level;
        psel && !penable && !pwrite && reg_sel(paddr) == SEL_LSTAT |=>
            prdata[0] == $past(cts_n);
    endproperty
    a_cts_level: assert property (p_cts_level) // R15
        else $error("status bit zero does not follow clear-to-send");

endmodule : uart_baud_and_data_status

// ===== uart_serial_node.sv
// Purpose: Remote serial node on the far side of the port's serial pins.
// Assumes: Bit time is sixteen divisor periods of pclk.
// Notes:   Line idles high as with a pull-up; this node makes no clock.
`timescale 1ns/100ps

module uart_serial_node (
    // Clock and bit timing
    input  wire logic        pclk,
    input  wire logic [15:0] div,
    // Serial line
    input  wire logic        rx_line,
    output logic             tx_line
);
    logic [7:0] got[$];
    int         bit_clks;

    // Bit time in clocks; a zero divisor behaves as one
    assign bit_clks = 16 * ((div == 16'h0000) ? 1 : int'(div));

    initial tx_line = 1'b1;

    // One frame, LSB first; stop_ok low leaves the stop bit missing
    task automatic send(input logic [7:0] d, input logic has9, input logic b9,
                        input logic stop_ok);
        logic bits[$];
        bits = {1'b0};
        for (int i = 0; i < 8; i++) begin
            bits.push_back(d[i]);
        end
        if (has9) begin
            bits.push_back(b9);
        end
        bits.push_back(stop_ok);
        bits.push_back(1'b1); // Idle gap so the next start edge is clean
        foreach (bits[i]) begin
            @(posedge pclk);
            tx_line <= bits[i];
            repeat (bit_clks - 1) @(posedge pclk);
        end
    endtask : send

    // Receiver samples mid-bit; a wrong bit rate garbles the byte
    initial begin
        logic [7:0] b;
        forever begin
            @(negedge rx_line);
            repeat (bit_clks / 2) @(posedge pclk);
            for (int i = 0; i < 8; i++) begin
                repeat (bit_clks) @(posedge pclk);
                b[i] = rx_line;
            end
            got.push_back(b);
            repeat (bit_clks) @(posedge pclk);
        end
    end
endmodule : uart_serial_node

// ===== uart_baud_and_data_status_bench.sv
// Purpose: Self-checking bench of the serial port divisor, data and status.
// Assumes: APB byte address is four times the register index.
// Notes:   Timer check waits one full count from reset, about 65k cycles.
`timescale 1ns/100ps
`include "uart_consts.svh"

`define CHK(got, exp, msg) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp); \
        end \
    end

module uart_baud_and_data_status_bench;
    logic        pclk, presetn, psel, penable, pwrite, cts_n, er;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed;
    logic        pready, pslverr, serial_out_pin, rx_irq;
    wire         serial_in_pin;
    logic [15:0] cur_div;
    logic [7:0]  m_data, d0, d1;
    int          err_count, num_checks, n;
    bit          m_rda, m_pe, m_oe, m_fe, m_brk, m_nf, m_nin, m_prev9, m_par, m_odd, m_mp;
    logic [11:0] ridx[5] = '{`IDX_MSTAT, `IDX_CTRL0, `IDX_CTRL1, `IDX_DIV_HI, `IDX_DIV_LO};
    logic [7:0]  rexp[5] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
    logic [15:0] tdiv[3] = '{16'h0100, 16'h0003, 16'h0001};

    uart_baud_and_data_status u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_in_pin(serial_in_pin),
        .cts_n(cts_n), .serial_out_pin(serial_out_pin), .rx_irq(rx_irq)
    );

    uart_serial_node u_node (
        .pclk(pclk), .div(cur_div), .rx_line(serial_out_pin), .tx_line(serial_in_pin)
    );

    // Clock, 40 ns period
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Line status as the model sees it, transmitter idle
    function automatic logic [31:0] exp_lstat();
        return {24'h0, m_rda, m_pe, m_oe, m_fe, m_brk, 2'b11, cts_n};
    endfunction : exp_lstat

    // One APB transfer; waits up to 50 cycles for pready
    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] wd);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) `CHK(pready, 1'b1, "no answer")
    endtask : apb

    // Cycles between two receiver interrupt pulses
    task automatic irq_gap(output int c);
        int k;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (rx_irq !== 1'b1 && k < 70000);
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (rx_irq !== 1'b1 && c < 70000);
    endtask : irq_gap

    // Far side sends a frame; model updates its flags
    task automatic rx_frame(input logic [7:0] d, input bit b9, input bit stop_ok);
        u_node.send(d, m_par | m_mp, b9, stop_ok);
        repeat (4) @(posedge pclk);
        if (m_rda) begin
            m_oe = 1;
        end else begin
            m_data = d;
            m_rda  = 1;
            m_pe   = m_par && !m_mp && (b9 != (^d ^ m_odd));
            m_fe   = !stop_ok;
            m_brk  = (d == 8'h00) && !b9 && !stop_ok;
            m_nf   = m_mp && !b9 && m_prev9;
            m_nin  = m_mp && b9;
            if (m_mp) m_prev9 = b9;
        end
    endtask : rx_frame

    // Status before and after a data read, and the byte itself
    task automatic rx_check;
        apb(1'b0, `IDX_LSTAT, 8'h00);
        `CHK(rd, exp_lstat(), "line status")
        if (m_mp) begin
            apb(1'b0, `IDX_MSTAT, 8'h00);
            `CHK(rd, {30'h0, m_nf, m_nin}, "multinode status")
        end
        apb(1'b0, `IDX_DATA, 8'h00);
        `CHK(rd[7:0], m_data, "rx data")
        if (!m_rda) m_oe = 0;
        {m_rda, m_pe, m_fe, m_brk, m_nf, m_nin} = '0;
        apb(1'b0, `IDX_LSTAT, 8'h00);
        `CHK(rd, exp_lstat(), "status after read")
    endtask : rx_check

    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    // Watchdog, well above the expected run length
    initial begin
        repeat (95000) @(posedge pclk);
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        stop_test();
    end

    // Main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        cts_n   = 1'b1;
        presetn = 1'b0;
        cur_div = 16'h0001;
        seed    = 32'h204846fa;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, clear-to-send level, read-only status, unmapped place
        apb(1'b0, `IDX_LSTAT, 8'h00);
        `CHK(rd, 32'h07, "reset status")
        cts_n <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b1, `IDX_LSTAT, 8'hff);
        apb(1'b0, `IDX_LSTAT, 8'h00);
        `CHK(rd, 32'h06, "cts low")
        foreach (ridx[i]) begin
            apb(1'b0, ridx[i], 8'h00);
            `CHK({er, rd}, {9'h0, 16'h0, rexp[i]}, "reset value")
        end
        apb(1'b0, 12'hf45, 8'h00);
        `CHK({er, rd}, {1'b1, 32'h0}, "unmapped")
        // Timer use: port off, divisor loaded, then interrupt on
        apb(1'b1, `IDX_CTRL0, 8'h00);
        foreach (tdiv[i]) begin
            apb(1'b1, `IDX_DIV_HI, tdiv[i][15:8]);
            apb(1'b1, `IDX_DIV_LO, tdiv[i][7:0]);
            apb(1'b1, `IDX_CTRL1, 8'h01 << `C1_DIVISOR_TIMER_IRQ_ENABLE);
            irq_gap(n); // First gap may still run off the old value
            irq_gap(n);
            `CHK(n, int'(tdiv[i]), "timer interval")
        end
        apb(1'b1, `IDX_CTRL1, 8'h00);
        // Two bytes back to back; the second waits in the holding register
        apb(1'b1, `IDX_CTRL0, 8'h01 << `C0_TEN);
        seed = lfsr(seed);
        d0   = seed[7:0];
        seed = lfsr(seed);
        d1   = seed[7:0];
        apb(1'b1, `IDX_DATA, d0);
        apb(1'b1, `IDX_DATA, d1);
        apb(1'b0, `IDX_LSTAT, 8'h00);
        `CHK(rd[2:1], 2'b00, "tx busy")
        n = 0;
        while (u_node.got.size() < 2 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        repeat (64) @(posedge pclk);
        `CHK(u_node.got[0], d0, "tx byte 0")
        `CHK(u_node.got[1], d1, "tx byte 1")
        apb(1'b0, `IDX_LSTAT, 8'h00);
        `CHK(rd[2:1], 2'b11, "tx done")
        // Receive: plain, framing error, break, then overrun
        apb(1'b1, `IDX_CTRL0, 8'h01 << `C0_REN);
        seed = lfsr(seed);
        rx_frame(seed[7:0], 1'b0, 1'b1);
        rx_check();
        rx_frame(seed[15:8], 1'b0, 1'b0);
        rx_check();
        rx_frame(8'h00, 1'b0, 1'b0);
        rx_check();
        rx_frame(seed[23:16], 1'b0, 1'b1);
        rx_frame(seed[31:24], 1'b0, 1'b1);
        rx_check();
        rx_check();
        // Parity even and odd, right and wrong
        m_par = 1;
        for (int i = 0; i < 4; i++) begin
            m_odd = i[0];
            apb(1'b1, `IDX_CTRL0, 8'hd0 | ({7'h0, m_odd} << `C0_PSEL));
            seed = lfsr(seed);
            rx_frame(seed[7:0], (^seed[7:0]) ^ m_odd ^ i[1], 1'b1);
            rx_check();
        end
        // Loopback, odd parity, two stops; held off until clear-to-send low
        cts_n <= 1'b1;
        apb(1'b1, `IDX_CTRL0, 8'hfb);
        seed = lfsr(seed);
        apb(1'b1, `IDX_DATA, seed[7:0]);
        repeat (40) @(posedge pclk);
        apb(1'b0, `IDX_LSTAT, 8'h00);
        `CHK(rd[2:0], 3'b001, "cts hold off")
        cts_n <= 1'b0;
        repeat (220) @(posedge pclk);
        m_data = seed[7:0];
        m_rda  = 1;
        rx_check();
        // Multinode: address byte, first data, further data
        m_par = 0;
        m_mp  = 1;
        apb(1'b1, `IDX_CTRL0, 8'h01 << `C0_REN);
        apb(1'b1, `IDX_CTRL1, 8'h01 << `C1_MPEN);
        apb(1'b1, `IDX_MSTAT, 8'h00);
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            rx_frame(seed[7:0], i == 0, 1'b1);
            rx_check();
        end
        stop_test();
    end
endmodule : uart_baud_and_data_status_bench
